// [emi_chk.sv]
// Checker for the external memory interface pins and move handshake.
// Assumes it is bound to emi_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module emi_chk (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // Move handshake
    input wire logic       mv_start,
    input wire logic       mv_busy,
    input wire logic       mv_done,
    input wire logic       mv_onchip,
    // Pins
    input wire logic [7:0] ad_oe_n,
    input wire logic [7:0] ah_oe_n,
    input wire logic [7:0] al_oe_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       ale,
    input wire logic       pins_claimed
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_strobe_excl: assert property (!(!rd_n && !wr_n))
        else $error("read and write strobes low together");
    a_read_release: assert property (!rd_n |-> ad_oe_n == 8'hff)
        else $error("data drivers on during read");
    a_write_drive: assert property (!wr_n |-> ad_oe_n == 8'h00)
        else $error("data not driven during write");
    a_idle_release: assert property (!pins_claimed |-> rd_n && wr_n && !ale && (ad_oe_n & ah_oe_n & al_oe_n) == 8'hff)
        else $error("pins driven while not claimed");
    a_ale_drives: assert property (ale |-> ad_oe_n == 8'h00 && pins_claimed)
        else $error("latch strobe without address on shared pins");
    a_ale_gap: assert property ($fell(ale) |-> rd_n && wr_n)
        else $error("strobe without latch low phase");
    a_busy_end: assert property ($fell(mv_busy) |-> mv_done)
        else $error("busy ended without done");
    a_strobe_busy: assert property ((!rd_n || !wr_n) |-> mv_busy)
        else $error("strobe outside a move");
    a_onchip_quiet: assert property (mv_done && mv_onchip |-> !$past(mv_busy) && !$past(pins_claimed))
        else $error("on-chip move used the bus");
    a_start_taken: assert property (mv_start && !mv_busy |-> ##[1:2] (mv_busy || mv_done))
        else $error("move request not taken");

    c_read: cover property (!rd_n);
    c_write: cover property (!wr_n);
    c_latch: cover property ($fell(ale));
    c_onchip: cover property (mv_done && mv_onchip);
endmodule
`default_nettype wire

// [emi_mem_model.sv]
// Off-chip byte memory with address latch on the shared pins.
// Assumes low address byte selects a cell; upper address is ignored.
`timescale 1ns/100ps
`default_nettype none
module emi_mem_model (
    // Clock
    input wire logic       core_clk,
    // Bus
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       ale,
    input wire logic [7:0] ad_o,
    input wire logic [7:0] al_o,
    input wire logic [7:0] al_oe_n,
    output logic [7:0]     ad_i
);
    logic [7:0] mem [0:255];
    logic [7:0] lat;
    logic [7:0] last;
    logic [7:0] a;

    assign a = (al_oe_n == 8'h00) ? al_o : lat;
    assign ad_i = !rd_n ? mem[a] : ~last;

    always @(posedge core_clk)
    begin
        if (ale)
            lat <= ad_o;
        if (!wr_n)
            mem[a] <= ad_o;
        if (!rd_n)
            last <= mem[a];
    end
endmodule
`default_nettype wire

// [emi_pkg.sv]
// External memory interface package: register map, field layout, reset values, types.
// Assumes a single core clock domain; registers reached over a plain strobe port.
package emi_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] EMI_ADDR_PAGE   = 8'haa;
    localparam logic [7:0] EMI_ADDR_CONFIG = 8'hc7;
    localparam logic [7:0] EMI_ADDR_TIMING = 8'hf7;
    localparam logic [7:0] EMI_ADDR_STATUS = 8'hc8;

    localparam logic [7:0] EMI_RST_PAGE   = 8'h00;
    localparam logic [4:0] EMI_RST_CONFIG = 5'h03;
    localparam logic [7:0] EMI_RST_TIMING = 8'hff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int EMI_CFG_MUX_BIT  = 4;
    localparam int EMI_CFG_MODE_LO  = 2;
    localparam int EMI_CFG_LATCH_LO = 0;
    localparam int EMI_TC_SETUP_LO  = 6;
    localparam int EMI_TC_WIDTH_LO  = 2;
    localparam int EMI_TC_HOLD_LO   = 0;

    // On-chip RAM: 1k bytes, ten address bits
    localparam int EMI_ONCHIP_BITS = 10;

    // Fixed overhead of an off-chip move beyond the programmed counts
    localparam logic [5:0] EMI_MOVE_OVERHEAD = 6'h04;

    typedef enum logic [1:0] {
        EMI_MODE_INTERNAL,
        EMI_MODE_SPLIT_NOBANK,
        EMI_MODE_SPLIT_BANK,
        EMI_MODE_EXTERNAL
    } emi_mode_t;

    typedef enum {
        EMI_ST_IDLE,
        EMI_ST_LATCH_HI,
        EMI_ST_LATCH_LO,
        EMI_ST_SETUP,
        EMI_ST_STROBE,
        EMI_ST_HOLD,
        EMI_ST_TAIL
    } emi_state_t;

    // Request from the core for one external data move
    typedef struct packed {
        logic        wide;
        logic        write;
        logic [15:0] ptr;
        logic [7:0]  index;
        logic [7:0]  wdata;
    } emi_req_t;

    // Decoded routing of one move
    typedef struct packed {
        logic        offchip;
        logic        drive_high;
        logic [15:0] addr;
    } emi_route_t;

    // Pin group: output, enable (low = driving)
    typedef struct packed {
        logic [7:0] ad_o;
        logic [7:0] ad_oe_n;
        logic [7:0] ah_o;
        logic [7:0] ah_oe_n;
        logic [7:0] al_o;
        logic [7:0] al_oe_n;
        logic       rd_n;
        logic       wr_n;
        logic       ale;
        logic       claim;
    } emi_pins_t;

endpackage

// [emi_regs.sv]
// Register file: page select, configuration, timing control, status.
// Assumes one-cycle strobes, never both at once; read data one cycle later.
`timescale 1ns/100ps
`default_nettype none
module emi_regs
    import emi_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Status in
    input  wire logic [7:0] status,
    // Values out
    output logic [7:0]      page,
    output logic [4:0]      config_bits,
    output logic [7:0]      timing
);

    typedef struct packed {
        logic [7:0] page;
        logic [4:0] cfg;
        logic [7:0] tc;
        logic [7:0] rdata;
    } emi_regs_state_t;

    emi_regs_state_t s_r;
    emi_regs_state_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.rdata = 8'h00;
        if (reg_wr)
        begin
            if (reg_addr == EMI_ADDR_PAGE)
                s_nxt.page = reg_wdata;
            else if (reg_addr == EMI_ADDR_CONFIG)
                s_nxt.cfg = reg_wdata[4:0];
            else if (reg_addr == EMI_ADDR_TIMING)
                s_nxt.tc = reg_wdata;
        end
        if (reg_rd)
        begin
            if (reg_addr == EMI_ADDR_PAGE)
                s_nxt.rdata = s_r.page;
            else if (reg_addr == EMI_ADDR_CONFIG)
                s_nxt.rdata = {3'h0, s_r.cfg};
            else if (reg_addr == EMI_ADDR_TIMING)
                s_nxt.rdata = s_r.tc;
            else if (reg_addr == EMI_ADDR_STATUS)
                s_nxt.rdata = status;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r.page  <= EMI_RST_PAGE;
            s_r.cfg   <= EMI_RST_CONFIG;
            s_r.tc    <= EMI_RST_TIMING;
            s_r.rdata <= 8'h00;
        end
        else
            s_r <= s_nxt;
    end

    assign reg_rdata   = s_r.rdata;
    assign page        = s_r.page;
    assign config_bits = s_r.cfg;
    assign timing      = s_r.tc;

endmodule
`default_nettype wire

// [emi_route.sv]
// Address steering for one external data move.
// Assumes request fields are stable while start is high.
`timescale 1ns/100ps
`default_nettype none
module emi_route
    import emi_pkg::*;
(
    // Configuration
    input  wire emi_mode_t  mode,
    input  wire logic [7:0] page,
    // Request
    input  wire emi_req_t   req,
    // Result
    output emi_route_t      route
);

    logic [15:0] eff;
    logic        above;

    always_comb
    begin
        eff   = req.wide ? req.ptr : {page, req.index};
        above = |eff[15:EMI_ONCHIP_BITS];
        route = '0;
        case (mode)
            EMI_MODE_INTERNAL:
            begin
                route.offchip    = 1'b0;
                route.drive_high = 1'b0;
                route.addr       = {6'h00, eff[EMI_ONCHIP_BITS-1:0]};
            end
            EMI_MODE_SPLIT_NOBANK:
            begin
                route.offchip    = above;
                route.drive_high = req.wide;
                route.addr       = eff;
            end
            EMI_MODE_SPLIT_BANK:
            begin
                route.offchip    = above;
                route.drive_high = 1'b1;
                route.addr       = eff;
            end
            default:
            begin
                route.offchip    = 1'b1;
                route.drive_high = req.wide;
                route.addr       = req.wide ? req.ptr : {8'h00, req.index};
            end
        endcase
    end

endmodule
`default_nettype wire

// [emi_top.sv]
// External memory interface: register file, address steering and strobe sequencer.
// Assumes the core pulses a move request for one cycle; pin inputs are asynchronous.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module emi_top
    import emi_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    // Core data move request
    input  wire logic       mv_start,
    input  wire logic       mv_wide,
    input  wire logic       mv_write,
    input  wire logic [15:0] mv_ptr,
    input  wire logic [7:0] mv_index,
    input  wire logic [7:0] mv_wdata,
    output logic            mv_busy,
    output logic            mv_done,
    output logic            mv_onchip,
    output logic [15:0]     mv_addr,
    output logic [7:0]      mv_rdata,
    // Shared data or address/data pins
    input  wire logic [7:0] ad_i,
    output logic [7:0]      ad_o,
    output logic [7:0]      ad_oe_n,
    // Address high pins
    output logic [7:0]      ah_o,
    output logic [7:0]      ah_oe_n,
    // Address low pins (separate-pin mode)
    output logic [7:0]      al_o,
    output logic [7:0]      al_oe_n,
    // Strobes
    output logic            rd_n,
    output logic            wr_n,
    output logic            ale,
    output logic            pins_claimed
);

    // ------------------------------------------------------------
    // Registers and steering
    // ------------------------------------------------------------
    logic [7:0] page;
    logic [4:0] cfg;
    logic [7:0] tc;
    logic [7:0] status;
    emi_req_t   req;
    emi_route_t route;

    // ------------------------------------------------------------
    // Move request
    // ------------------------------------------------------------
    assign req = '{wide:  mv_wide,
                   write: mv_write,
                   ptr:   mv_ptr,
                   index: mv_index,
                   wdata: mv_wdata};

    emi_regs u_regs (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_rdata   (reg_rdata),
        .status      (status),
        .page        (page),
        .config_bits (cfg),
        .timing      (tc)
    );

    emi_route u_route (
        .mode  (emi_mode_t'(cfg[EMI_CFG_MODE_LO +: 2])),
        .page  (page),
        .req   (req),
        .route (route)
    );

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    logic [7:0] ad_meta_r;
    logic [7:0] ad_sync_r;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ad_meta_r <= 8'h00;
            ad_sync_r <= 8'h00;
        end
        else
        begin
            ad_meta_r <= ad_i;
            ad_sync_r <= ad_meta_r;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef struct packed {
        emi_state_t  st;
        logic [3:0]  cnt;
        logic        write;
        logic        mux;
        logic        drive_high;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic        busy;
        logic        done;
        logic        onchip;
        logic        last_off;
        logic [1:0]  cap;
        emi_pins_t   pins;
    } emi_top_state_t;

    emi_top_state_t s_r;
    emi_top_state_t s_nxt;

    // ------------------------------------------------------------
    // Timing fields
    // ------------------------------------------------------------
    logic [1:0] setup_cnt;
    logic [3:0] width_cnt;
    logic [1:0] hold_cnt;
    logic [1:0] latch_cnt;

    assign setup_cnt = tc[EMI_TC_SETUP_LO +: 2];
    assign width_cnt = tc[EMI_TC_WIDTH_LO +: 4];
    assign hold_cnt  = tc[EMI_TC_HOLD_LO +: 2];
    assign latch_cnt = cfg[EMI_CFG_LATCH_LO +: 2];

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.cnt  = s_r.cnt - 4'h1;
        s_nxt.cap  = {s_r.cap[0], 1'b0};
        case (s_r.st)
            EMI_ST_IDLE:
            begin
                if (mv_start)
                begin
                    s_nxt.addr       = route.addr;
                    s_nxt.write      = mv_write;
                    s_nxt.wdata      = mv_wdata;
                    s_nxt.onchip     = !route.offchip;
                    s_nxt.drive_high = route.drive_high;
                    s_nxt.mux        = !cfg[EMI_CFG_MUX_BIT];
                    if (!route.offchip)
                        s_nxt.done = 1'b1;
                    else
                    begin
                        s_nxt.busy       = 1'b1;
                        s_nxt.pins.claim = 1'b1;
                        s_nxt.pins.ah_o  = route.addr[15:8];
                        s_nxt.pins.ah_oe_n = route.drive_high ? 8'h00 : 8'hff;
                        if (!cfg[EMI_CFG_MUX_BIT])
                        begin
                            s_nxt.st           = EMI_ST_LATCH_HI;
                            s_nxt.cnt          = {2'b00, latch_cnt};
                            s_nxt.pins.ale     = 1'b1;
                            s_nxt.pins.ad_o    = route.addr[7:0];
                            s_nxt.pins.ad_oe_n = 8'h00;
                        end
                        else
                        begin
                            s_nxt.st           = EMI_ST_SETUP;
                            s_nxt.cnt          = {2'b00, setup_cnt};
                            s_nxt.pins.al_o    = route.addr[7:0];
                            s_nxt.pins.al_oe_n = 8'h00;
                        end
                    end
                end
            end
            EMI_ST_LATCH_HI:
            begin
                if (s_r.cnt == 4'h0)
                begin
                    s_nxt.st       = EMI_ST_LATCH_LO;
                    s_nxt.cnt      = {2'b00, latch_cnt};
                    s_nxt.pins.ale = 1'b0;
                end
            end
            EMI_ST_LATCH_LO:
            begin
                if (s_r.cnt == 4'h0)
                begin
                    s_nxt.st           = EMI_ST_SETUP;
                    s_nxt.cnt          = {2'b00, setup_cnt};
                    s_nxt.pins.ad_oe_n = 8'hff;
                end
            end
            EMI_ST_SETUP:
            begin
                if (s_r.cnt == 4'h0)
                begin
                    s_nxt.st           = EMI_ST_STROBE;
                    s_nxt.cnt          = width_cnt;
                    s_nxt.pins.rd_n    = s_r.write;
                    s_nxt.pins.wr_n    = !s_r.write;
                    s_nxt.pins.ad_o    = s_r.wdata;
                    s_nxt.pins.ad_oe_n = s_r.write ? 8'h00 : 8'hff;
                end
            end
            EMI_ST_STROBE:
            begin
                if (s_r.cnt == 4'h0)
                begin
                    s_nxt.st        = EMI_ST_HOLD;
                    s_nxt.cnt       = {2'b00, hold_cnt};
                    s_nxt.pins.rd_n = 1'b1;
                    s_nxt.pins.wr_n = 1'b1;
                    s_nxt.cap[0]    = !s_r.write;
                end
            end
            EMI_ST_HOLD:
            begin
                if (s_r.cnt == 4'h0)
                begin
                    s_nxt.st  = EMI_ST_TAIL;
                    s_nxt.cnt = 4'h1;
                end
            end
            default:
            begin
                if (s_r.cnt == 4'h0)
                begin
                    s_nxt.st       = EMI_ST_IDLE;
                    s_nxt.busy     = 1'b0;
                    s_nxt.done     = 1'b1;
                    s_nxt.last_off = 1'b1;
                    s_nxt.pins     = '{ad_o:    8'h00,
                                       ad_oe_n: 8'hff,
                                       ah_o:    8'h00,
                                       ah_oe_n: 8'hff,
                                       al_o:    8'h00,
                                       al_oe_n: 8'hff,
                                       rd_n:    1'b1,
                                       wr_n:    1'b1,
                                       ale:     1'b0,
                                       claim:   1'b0};
                end
            end
        endcase

        // Pins sampled at the last strobe edge arrive two cycles later through the synchroniser
        if (s_r.cap[1])
            s_nxt.rdata = ad_sync_r;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_r          <= '0;
            s_r.st       <= EMI_ST_IDLE;
            s_r.pins.ad_oe_n <= 8'hff;
            s_r.pins.ah_oe_n <= 8'hff;
            s_r.pins.al_oe_n <= 8'hff;
            s_r.pins.rd_n <= 1'b1;
            s_r.pins.wr_n <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    assign status = {5'h00, s_r.last_off, s_r.pins.claim, s_r.busy};

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign mv_busy      = s_r.busy;
    assign mv_done      = s_r.done;
    assign mv_onchip    = s_r.onchip;
    assign mv_addr      = s_r.addr;
    assign mv_rdata     = s_r.rdata;
    assign ad_o         = s_r.pins.ad_o;
    assign ad_oe_n      = s_r.pins.ad_oe_n;
    assign ah_o         = s_r.pins.ah_o;
    assign ah_oe_n      = s_r.pins.ah_oe_n;
    assign al_o         = s_r.pins.al_o;
    assign al_oe_n      = s_r.pins.al_oe_n;
    assign rd_n         = s_r.pins.rd_n;
    assign wr_n         = s_r.pins.wr_n;
    assign ale          = s_r.pins.ale;
    assign pins_claimed = s_r.pins.claim;

endmodule
`default_nettype wire

// [test_external_memory_interface.sv]
// Self-checking bench for the external memory interface.
// Assumes emi_top with emi_mem_model on its pins and emi_chk bound.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got=%h exp=%h", $time, (g), (e)); end end
module test_external_memory_interface
    import emi_pkg::*;
;
    logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
    logic mv_start = 0, mv_wide = 0, mv_write = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, mv_index = 0, mv_wdata = 0;
    logic [15:0] mv_ptr = 0;
    logic [7:0] reg_rdata, mv_rdata, ad_i, ad_o, ad_oe_n, ah_o, ah_oe_n, al_o, al_oe_n;
    logic [15:0] mv_addr;
    logic mv_busy, mv_done, mv_onchip, rd_n, wr_n, ale, pins_claimed, hdrv;
    logic [7:0] pa, ph, pd;
    int fails = 0, checks = 0, cyc = 0, nb, ns, na, npre, npost;

    always #2 core_clk = ~core_clk;

    emi_top i_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .mv_start, .mv_wide, .mv_write, .mv_ptr, .mv_index, .mv_wdata, .mv_busy, .mv_done,
        .mv_onchip, .mv_addr, .mv_rdata, .ad_i, .ad_o, .ad_oe_n, .ah_o, .ah_oe_n, .al_o,
        .al_oe_n, .rd_n, .wr_n, .ale, .pins_claimed);
    emi_mem_model i_mem (.core_clk, .rd_n, .wr_n, .ale, .ad_o, .al_o, .al_oe_n, .ad_i);

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic reg_w(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 0;
    endtask

    task automatic reg_r(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask

    task automatic setup(input logic nm, input logic [1:0] md, input logic [1:0] l, input logic [7:0] tc);
        reg_w(EMI_ADDR_CONFIG, {3'h0, nm, md, l});
        reg_w(EMI_ADDR_TIMING, tc);
    endtask

    task automatic mv(input logic w, input logic wr, input logic [15:0] dp, input logic [7:0] ix,
                      input logic [7:0] wd);
        int k;
        @(posedge core_clk);
        mv_start <= 1; mv_wide <= w; mv_write <= wr; mv_ptr <= dp; mv_index <= ix; mv_wdata <= wd;
        @(posedge core_clk);
        mv_start <= 0;
        nb = 0; ns = 0; na = 0; npre = 0; npost = 0; hdrv = 0; k = 0;
        #1;
        while (mv_done !== 1'b1 && k < 100)
        begin
            nb += (mv_busy === 1'b1);
            na += (ale === 1'b1);
            if (rd_n === 1'b0 || wr_n === 1'b0)
            begin
                ns++; pa = al_o; ph = ah_o; pd = ad_o; hdrv = (ah_oe_n !== 8'hff);
            end
            else if (mv_busy === 1'b1)
            begin
                if (ns == 0) npre++; else npost++;
            end
            @(posedge core_clk);
            #1 k++;
        end
        `CHK(k < 100, 1'b1)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] d;
        reg_r(EMI_ADDR_TIMING, d); `CHK(d, 8'hff)
        reg_r(EMI_ADDR_CONFIG, d); `CHK(d, 8'h03)
        reg_r(8'h10, d); `CHK(d, 8'h00)
        $display("test reset done");
    endtask

    task automatic t_internal;
        setup(1, 2'b00, 0, 8'h00);
        mv(1, 0, 16'h1403, 0, 0);
        `CHK(mv_onchip, 1'b1)
        `CHK(nb, 0)
        `CHK(mv_addr, 16'h0003)
        reg_w(EMI_ADDR_PAGE, 8'h05);
        mv(0, 1, 16'hffff, 8'h21, 8'h9a);
        `CHK(mv_addr, 16'h0121)
        `CHK(ns, 0)
        $display("test internal done");
    endtask

    task automatic t_timing;
        logic [7:0] tcs [4] = '{8'h00, 8'h5a, 8'hff, 8'h87};
        logic [7:0] tc;
        setup(1, 2'b01, 0, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            tc = tcs[i];
            reg_w(EMI_ADDR_TIMING, tc);
            mv(1, 1, {8'h80, 8'(i)}, 0, 8'hc0 + 8'(i));
            `CHK(nb, tc[7:6] + tc[5:2] + 1 + tc[1:0] + EMI_MOVE_OVERHEAD)
            `CHK(npre, tc[7:6] + 1)
            `CHK(ns, tc[5:2] + 1)
            `CHK(npost, tc[1:0] + 3)
            `CHK({ph, pa}, {8'h80, 8'(i)})
            `CHK(hdrv, 1'b1)
            `CHK(pd, 8'hc0 + 8'(i))
        end
        reg_w(EMI_ADDR_TIMING, 8'h5a);
        mv(1, 0, 16'h8002, 0, 0);
        `CHK(mv_rdata, 8'hc2)
        reg_w(EMI_ADDR_TIMING, 8'h00);
        mv(1, 0, 16'h8000, 0, 0);
        `CHK(mv_rdata, 8'hc0)
        $display("test timing done");
    endtask

    task automatic t_split;
        setup(1, 2'b01, 0, 8'h0c);
        reg_w(EMI_ADDR_PAGE, 8'h12);
        mv(0, 1, 0, 8'h34, 8'h5e);
        `CHK(mv_onchip, 1'b0)
        `CHK(hdrv, 1'b0)
        `CHK(pa, 8'h34)
        reg_w(EMI_ADDR_PAGE, 8'h00);
        mv(0, 0, 0, 8'h34, 0);
        `CHK(mv_onchip, 1'b1)
        setup(1, 2'b10, 0, 8'h0c);
        reg_w(EMI_ADDR_PAGE, 8'h12);
        mv(0, 0, 0, 8'h34, 0);
        `CHK(hdrv, 1'b1)
        `CHK({ph, pa}, 16'h1234)
        `CHK(mv_rdata, 8'h5e)
        mv(1, 0, 16'h03ff, 0, 0);
        `CHK(mv_onchip, 1'b1)
        mv(1, 0, 16'h0400, 0, 0);
        `CHK(mv_onchip, 1'b0)
        $display("test split done");
    endtask

    task automatic t_external;
        setup(1, 2'b11, 0, 8'h0c);
        mv(1, 1, 16'h0010, 0, 8'h44);
        `CHK(mv_onchip, 1'b0)
        `CHK({ph, pa}, 16'h0010)
        mv(0, 0, 0, 8'h10, 0);
        `CHK(mv_onchip, 1'b0)
        `CHK(hdrv, 1'b0)
        `CHK(pa, 8'h10)
        `CHK(mv_addr, 16'h0010)
        `CHK(mv_rdata, 8'h44)
        $display("test external done");
    endtask

    task automatic t_mux;
        logic [7:0] d;
        for (int l = 0; l < 4; l++)
        begin
            setup(0, 2'b11, 2'(l), 8'h0c);
            mv(1, 1, {8'h90, 8'(l)}, 0, 8'ha0 + 8'(l));
            `CHK(na, l + 1)
            `CHK(nb, 8 + 2 * (l + 1))
            `CHK(pd, 8'ha0 + 8'(l))
            mv(1, 0, {8'h90, 8'(l)}, 0, 0);
            `CHK(mv_rdata, 8'ha0 + 8'(l))
        end
        reg_r(EMI_ADDR_STATUS, d); `CHK(d, 8'h04)
        $display("test mux done");
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task close_out;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            close_out;
        end
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        resetn <= 1;
        t_reset;
        t_internal;
        t_timing;
        t_split;
        t_external;
        t_mux;
        close_out;
    end
endmodule
bind emi_top emi_chk i_chk (.core_clk, .resetn, .mv_start, .mv_busy, .mv_done, .mv_onchip,
    .ad_oe_n, .ah_oe_n, .al_oe_n, .rd_n, .wr_n, .ale, .pins_claimed);
`default_nettype wire
